// >>> hdl/pld_dialer.sv
// line supervision, relay control, interrupt ranking and alarm dialer
`timescale 1ns/100ps
`default_nettype none
`include "pld_consts.svh"
module pld_dialer #(
  parameter int unsigned CHANNELS  = 16,
  parameter longint unsigned GAP_CYC   = 64'(`PLD_GAP_SEC) * `PLD_CLK_HZ,
  parameter longint unsigned CYCLE_CYC = 64'(`PLD_CYCLE_MIN) * 60 * `PLD_CLK_HZ,
  parameter int unsigned RING_IDLE_CYC = `PLD_RING_IDLE_SEC * `PLD_CLK_HZ,
  parameter longint unsigned SEIZE_CYC  = 64'(`PLD_SEIZE_SEC) * `PLD_CLK_HZ,
  parameter longint unsigned DIGIT_CYC  = 64'(`PLD_CLK_HZ / `PLD_DIGIT_DIV),
  parameter longint unsigned LISTEN_CYC = 64'(`PLD_LISTEN_SEC) * `PLD_CLK_HZ
) (
  // clock and reset
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rst_n,
  // line side
  input  wire logic                    i_ring_sense_n,
  input  wire logic                    i_loop_reverse,
  input  wire logic                    i_ref_clk_358,
  input  wire pld_pkg::pld_tone_t      i_cprog_tone,
  input  wire logic                    i_cprog_valid,
  input  wire logic                    i_tone_rx_valid,
  // configuration
  input  wire logic [3:0]              i_ring_count,
  input  wire logic                    i_setup_mode,
  input  wire logic                    i_report_done,
  // number store write port
  input  wire logic                    i_num_wr,
  input  wire logic [2:0]              i_num_slot,
  input  wire logic [3:0]              i_num_idx,
  input  wire logic [3:0]              i_num_digit,
  // alarms and routing
  input  wire logic [CHANNELS-1:0]     i_alarm,
  input  wire logic [CHANNELS*3-1:0]   i_route,
  // relays and hook
  output logic                         o_line_select_relay_a,
  output logic                         o_line_select_relay_b,
  output logic                         o_off_hook,
  // tone generator and interrupts
  output pld_pkg::pld_digit_t          o_tone_tx,
  output logic                         o_tone_ref_clk,
  output pld_pkg::pld_irq_t            o_irq,
  output logic                         o_dial_active,
  output logic [2:0]                   o_dial_slot
);
  import pld_pkg::*;

  typedef enum logic [2:0] {
    PLD_IDLE, PLD_SEIZE, PLD_DIGIT, PLD_LISTEN, PLD_GAP, PLD_CYCLE
  } pld_state_t;

  localparam int unsigned SLOTS = `PLD_NUM_SLOTS;

  logic [3:0]  num_mem [SLOTS][`PLD_DIGITS];
  logic [3:0]  ring_cnt_reg;
  logic [31:0] ring_idle_reg;
  logic        sense_d_reg;
  logic        rev_d_reg;
  logic        in_call_reg;
  logic        alarm_off_hook;
  pld_state_t  state_reg;
  logic [2:0]  slot_reg;
  logic [3:0]  didx_reg;
  logic [63:0] tmr_reg;
  logic [SLOTS-1:0] mask_reg;
  logic [SLOTS-1:0] want;
  logic        ring_edge;

  // first populated slot at or above a start index, SLOTS if none
  function automatic logic [2:0] next_slot(input logic [SLOTS-1:0] m, input logic [2:0] from);
    logic [2:0] r;
    r = 3'(SLOTS);
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (m[i] && 3'(i) >= from) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // an alarm with a routed slot targets only that slot, else every populated slot
  always_comb begin
    want = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      if (i_alarm[c]) begin
        if (i_route[c*3 +: 3] != 3'h0 && i_route[c*3 +: 3] <= 3'(SLOTS)) begin
          want[i_route[c*3 +: 3] - 3'h1] = 1'b1;
        end else begin
          want = '1;
        end
      end
    end
    for (int s = 0; s < SLOTS; s++) begin
      if (num_mem[s][0] == `PLD_DIG_END) begin
        want[s] = 1'b0;
      end
    end
  end

  // stored numbers, digit f ends a number; not reset, software reloads them
  always_ff @(posedge i_core_clk) begin
    if (i_num_wr && i_num_slot < 3'(SLOTS)) begin
      num_mem[i_num_slot][i_num_idx] <= i_num_digit;
    end
  end

  assign ring_edge = sense_d_reg && !i_ring_sense_n && !in_call_reg;

  // sense history for edge detection
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sense_d_reg <= 1'b1;
      rev_d_reg   <= 1'b0;
    end else begin
      sense_d_reg <= i_ring_sense_n;
      rev_d_reg   <= i_loop_reverse;
    end
  end

  // ring counter, cleared after a quiet spell so calls do not merge
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ring_cnt_reg  <= 4'h0;
      ring_idle_reg <= 32'h0;
    end else if (in_call_reg || ring_idle_reg >= RING_IDLE_CYC) begin
      ring_cnt_reg  <= 4'h0;
      ring_idle_reg <= 32'h0;
    end else if (ring_edge) begin
      ring_cnt_reg  <= ring_cnt_reg + 4'h1;
      ring_idle_reg <= 32'h0;
    end else if (ring_cnt_reg != 4'h0 && i_ring_sense_n) begin
      ring_idle_reg <= ring_idle_reg + 32'h1;
    end
  end

  // inbound call hook state; low sense while off-hook is loop current
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_call_reg <= 1'b0;
    end else if (in_call_reg) begin
      if (i_ring_sense_n || (i_loop_reverse != rev_d_reg)) begin
        in_call_reg <= 1'b0;
      end
    end else if (ring_edge && i_ring_count != 4'h0 && ring_cnt_reg + 4'h1 >= i_ring_count
                 && !i_setup_mode && state_reg == PLD_IDLE) begin
      in_call_reg <= 1'b1;
    end
  end

  // outbound dial sequencer
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= PLD_IDLE;
      slot_reg  <= 3'h0;
      didx_reg  <= 4'h0;
      tmr_reg   <= 64'h0;
      mask_reg  <= '0;
      o_tone_tx <= '0;
    end else begin
      o_tone_tx.valid <= 1'b0;
      tmr_reg <= tmr_reg + 64'h1;
      // a delivered report ends the whole sequence from any active state
      if (i_report_done && state_reg != PLD_IDLE) begin
        state_reg <= PLD_IDLE;
      end else begin
      case (state_reg)
        PLD_IDLE: begin
          if (want != '0 && !in_call_reg && !i_setup_mode) begin
            mask_reg  <= want;
            slot_reg  <= next_slot(want, 3'h0);
            tmr_reg   <= 64'h0;
            state_reg <= PLD_SEIZE;
          end
        end
        PLD_SEIZE: begin
          didx_reg <= 4'h0;
          if (tmr_reg >= SEIZE_CYC) begin
            tmr_reg   <= 64'h0;
            state_reg <= PLD_DIGIT;
          end
        end
        PLD_DIGIT: begin
          if (tmr_reg >= DIGIT_CYC) begin
            tmr_reg <= 64'h0;
            if (num_mem[slot_reg][didx_reg] == `PLD_DIG_END) begin
              state_reg <= PLD_LISTEN;
            end else begin
              o_tone_tx.valid <= 1'b1;
              o_tone_tx.digit <= num_mem[slot_reg][didx_reg];
              if (didx_reg == 4'(`PLD_DIGITS - 1)) begin
                state_reg <= PLD_LISTEN;
              end else begin
                didx_reg <= didx_reg + 4'h1;
              end
            end
          end
        end
        PLD_LISTEN: begin
          if (tmr_reg >= LISTEN_CYC || (i_cprog_valid &&
                       i_cprog_tone inside {PLD_TONE_REORDER, PLD_TONE_FAST_BUSY,
                                            PLD_TONE_SLOW_BUSY})) begin
            tmr_reg <= 64'h0;
            if (next_slot(mask_reg, slot_reg + 3'h1) == 3'(SLOTS)) begin
              state_reg <= PLD_CYCLE;
            end else begin
              state_reg <= PLD_GAP;
            end
          end
        end
        PLD_GAP: begin
          if (tmr_reg >= GAP_CYC - 1) begin
            slot_reg  <= next_slot(mask_reg, slot_reg + 3'h1);
            tmr_reg   <= 64'h0;
            state_reg <= PLD_SEIZE;
          end
        end
        PLD_CYCLE: begin
          if (tmr_reg >= CYCLE_CYC - 1) begin
            slot_reg  <= next_slot(mask_reg, 3'h0);
            tmr_reg   <= 64'h0;
            state_reg <= PLD_SEIZE;
          end
        end
        default: state_reg <= PLD_IDLE;
      endcase
      end
    end
  end

  assign alarm_off_hook = state_reg inside {PLD_SEIZE, PLD_DIGIT, PLD_LISTEN};

  // relays and hook; setup mode powers the local jack instead of the line
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_line_select_relay_a <= 1'b0;
      o_line_select_relay_b <= 1'b0;
      o_off_hook            <= 1'b0;
    end else begin
      o_line_select_relay_a <= !i_setup_mode && (in_call_reg || alarm_off_hook);
      o_line_select_relay_b <= i_setup_mode;
      o_off_hook            <= !i_setup_mode && (in_call_reg || alarm_off_hook);
    end
  end

  // interrupt lines, index = ordinal-1; lower index wins
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= '0;
    end else begin
      o_irq.pending <= '0;
      o_irq.pending[`PLD_PRI_TONE]  <= i_tone_rx_valid;
      o_irq.pending[`PLD_PRI_CPROG] <= i_cprog_valid;
      o_irq.pending[`PLD_PRI_RING]  <= !i_ring_sense_n && !in_call_reg;
      o_irq.any <= i_tone_rx_valid || i_cprog_valid || (!i_ring_sense_n && !in_call_reg);
      if (i_tone_rx_valid) begin
        o_irq.top <= `PLD_PRI_TONE;
      end else if (i_cprog_valid) begin
        o_irq.top <= `PLD_PRI_CPROG;
      end else begin
        o_irq.top <= `PLD_PRI_RING;
      end
    end
  end

  // shared tone reference passed to decoder and generator
  assign o_tone_ref_clk = i_ref_clk_358;
  assign o_dial_active  = state_reg != PLD_IDLE;
  assign o_dial_slot    = slot_reg;
endmodule
`default_nettype wire

// >>> hdl/pld_consts.svh
// timing counts and encodings for the phone line alarm dialer
`ifndef PLD_CONSTS_SVH
`define PLD_CONSTS_SVH
`define PLD_CLK_HZ        100000000
`define PLD_GAP_SEC       60
`define PLD_CYCLE_MIN     10
`define PLD_RING_IDLE_SEC 8
`define PLD_SEIZE_SEC     2
`define PLD_DIGIT_DIV     10
`define PLD_LISTEN_SEC    45
`define PLD_NUM_SLOTS     5
`define PLD_DIGITS        16
`define PLD_PRI_TONE      3'd4
`define PLD_PRI_CPROG     3'd5
`define PLD_PRI_RING      3'd6
`define PLD_DIG_END       4'hf
`endif

// >>> hdl/pld_pkg.sv
// types shared by the phone line alarm dialer
`include "pld_consts.svh"
package pld_pkg;
  typedef enum logic [2:0] {
    PLD_TONE_NONE, PLD_TONE_RINGBACK, PLD_TONE_REORDER,
    PLD_TONE_FAST_BUSY, PLD_TONE_SLOW_BUSY, PLD_TONE_DIAL
  } pld_tone_t;
  typedef struct packed {
    logic       valid;
    logic [3:0] digit;
  } pld_digit_t;
  typedef struct packed {
    logic [7:0] pending; // one bit per hardware interrupt source, 0 = highest
    logic [2:0] top;     // pending index of highest pending source
    logic       any;
  } pld_irq_t;
endpackage

// >>> verification/pld_dialer_monitor.sv
// checker for line supervision, relays and interrupt ranking
`timescale 1ns/100ps
`default_nettype none
module pld_dialer_monitor (
  // clock and reset
  input wire logic             i_core_clk,
  input wire logic             i_rst_n,
  // inputs
  input wire logic             i_ring_sense_n,
  input wire logic             i_loop_reverse,
  input wire logic             i_ref_clk_358,
  input wire logic             i_tone_rx_valid,
  // outputs
  input wire logic             o_line_select_relay_a,
  input wire logic             o_line_select_relay_b,
  input wire logic             o_off_hook,
  input wire logic             o_tone_ref_clk,
  input wire pld_pkg::pld_irq_t o_irq,
  input wire logic             o_dial_active
);
  import pld_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic [3:0] hist_reg;
  // recent sense samples, so an answer can be traced back to a ring edge
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) hist_reg <= 4'hf;
    else hist_reg <= {hist_reg[2:0], i_ring_sense_n};
  end
  a_ring_irq_raise: assert property ($fell(i_ring_sense_n) && !o_off_hook |=> o_irq.pending[6])
    else $error("ring interrupt missing");
  a_tone_irq_raise: assert property (i_tone_rx_valid |=> o_irq.pending[4])
    else $error("tone interrupt missing");
  a_irq_rank_top: assert property (o_irq.any |-> o_irq.pending[o_irq.top] &&
    (o_irq.pending & ((8'h01 << o_irq.top) - 8'h01)) == 8'h00) else $error("bad irq rank");
  a_answer_on_ring: assert property ($rose(o_off_hook) && !o_dial_active |->
    |(~hist_reg[2:0] & hist_reg[3:1])) else $error("answer without ring edge");
  a_line_held: assert property ((o_off_hook && !o_dial_active && !i_ring_sense_n &&
    $stable(i_loop_reverse))[*3] |=> o_off_hook) else $error("line dropped");
  a_reverse_hangup: assert property (o_off_hook && !o_dial_active && $changed(i_loop_reverse)
    |-> ##[1:3] !o_off_hook) else $error("no hang up on reversal");
  a_loss_hangup: assert property (o_off_hook && !o_dial_active && i_ring_sense_n |->
    ##[1:3] !o_off_hook) else $error("no hang up on loop loss");
  a_relay_exclusive: assert property (!(o_line_select_relay_a && o_line_select_relay_b))
    else $error("both relays on");
  a_ref_shared: assert property (o_tone_ref_clk == i_ref_clk_358)
    else $error("tone reference differs");
  c_answer: cover property ($rose(o_off_hook));
  c_dial: cover property ($rose(o_dial_active));
  c_ring_top: cover property (o_irq.any && o_irq.top == 3'd6);
endmodule
bind pld_dialer pld_dialer_monitor pld_dialer_monitor_inst (.i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n), .i_ring_sense_n(i_ring_sense_n), .i_loop_reverse(i_loop_reverse),
  .i_ref_clk_358(i_ref_clk_358), .i_tone_rx_valid(i_tone_rx_valid), .o_irq(o_irq),
  .o_line_select_relay_a(o_line_select_relay_a), .o_off_hook(o_off_hook),
  .o_line_select_relay_b(o_line_select_relay_b), .o_tone_ref_clk(o_tone_ref_clk),
  .o_dial_active(o_dial_active));
`default_nettype wire

// >>> verification/pld_line_model.sv
// telephone line and remote caller as seen at the coupler
`timescale 1ns/100ps
`default_nettype none
module pld_line_model (
  // clock and hook state
  input  wire logic i_core_clk,
  input  wire logic i_off_hook,
  // line indications
  output var logic  o_ring_sense_n,
  output var logic  o_loop_reverse
);
  logic ring_reg = 1'b0;
  logic lost_reg = 1'b0;
  initial o_ring_sense_n = 1'b1;
  initial o_loop_reverse = 1'b0;
  // opto output: pulled high unless ring voltage or loop current is present
  always @(posedge i_core_clk) o_ring_sense_n <= i_off_hook ? lost_reg : ~ring_reg;
  // ring bursts of 20 cycles with 30 quiet cycles between
  task automatic ring(input int n);
    repeat (n) begin
      @(negedge i_core_clk) ring_reg = 1'b1;
      repeat (20) @(negedge i_core_clk);
      ring_reg = 1'b0;
      repeat (30) @(negedge i_core_clk);
    end
  endtask
  // remote hang up by polarity flip
  task automatic reverse();
    @(negedge i_core_clk) o_loop_reverse = ~o_loop_reverse;
  endtask
  // remote hang up by dropping loop current
  task automatic drop();
    lost_reg = 1'b1;
    repeat (10) @(negedge i_core_clk);
    lost_reg = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_pld_dialer.sv
// self-checking bench for the alarm dialer
`timescale 1ns/100ps
`default_nettype none
module tb_pld_dialer import pld_pkg::*;;
  logic       clk, rst_n, ring_n, rev, ref_clk, cpv, trx, setup, rep, wr;
  logic       rly_a, rly_b, hook, dial, tref;
  logic [3:0] rcnt, idx, dig;
  logic [2:0] slot, wslot;
  logic [15:0] alarm;
  logic [47:0] route;
  logic [4:0] exp_q[$], key, cand, last;
  logic [3:0] dig_q[$];
  pld_tone_t  tone;
  pld_digit_t ttx;
  pld_irq_t   irq;
  int         fails, total_checks, hold, cyc, c;
  int         rt[3] = '{0, 3, 5};
  pld_dialer #(.GAP_CYC(50), .CYCLE_CYC(100), .RING_IDLE_CYC(200), .SEIZE_CYC(10),
    .DIGIT_CYC(4), .LISTEN_CYC(30)) pld_dialer_inst (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_ring_sense_n(ring_n), .i_loop_reverse(rev),
    .i_ref_clk_358(ref_clk), .i_cprog_tone(tone), .i_cprog_valid(cpv),
    .i_tone_rx_valid(trx), .i_ring_count(rcnt), .i_setup_mode(setup), .i_report_done(rep),
    .i_num_wr(wr), .i_num_slot(wslot), .i_num_idx(idx), .i_num_digit(dig),
    .i_alarm(alarm), .i_route(route), .o_line_select_relay_a(rly_a),
    .o_line_select_relay_b(rly_b), .o_off_hook(hook), .o_tone_tx(ttx),
    .o_tone_ref_clk(tref), .o_irq(irq), .o_dial_active(dial), .o_dial_slot(slot));
  pld_line_model pld_line_model_inst (.i_core_clk(clk), .i_off_hook(hook),
    .o_ring_sense_n(ring_n), .o_loop_reverse(rev));
  assign key = dial ? {2'b01, slot} : {hook, 4'h0};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // tone reference runs unrelated to the core clock
  initial begin
    ref_clk = 1'b0;
    forever #139.7 ref_clk = ~ref_clk;
  end
  // random decoder activity keeps the interrupt ranking busy
  always @(negedge clk) if (rst_n) begin
    trx <= ($urandom % 5) == 0;
    cpv <= ($urandom % 7) == 0;
    tone <= pld_tone_t'($urandom % 6);
  end
  // a result is taken once the line state has held four cycles, hiding skew
  always @(negedge clk) if (rst_n) begin
    if (key !== cand) begin
      cand = key;
      hold = 0;
    end else if (hold < 3) hold++;
    else if (hold == 3) begin
      hold = 4;
      if (cand !== last) begin
        last = cand;
        total_checks++;
        if (exp_q.size() == 0 || exp_q[0] !== cand) begin
          fails++;
          $display("BAD %0t exp=%h got=%h", $time, exp_q.size() ? exp_q[0] : 5'bx, cand);
        end
        if (exp_q.size() != 0) exp_q.pop_front();
      end
    end
  end
  // every tone digit sent must be the next stored digit of the slot dialed
  always @(negedge clk) if (rst_n && ttx.valid) begin
    total_checks++;
    if (dig_q.size() == 0 || dig_q[0] !== ttx.digit) begin
      fails++;
      $display("BAD %0t exp=%h got=%h", $time, dig_q.size() ? dig_q[0] : 4'bx, ttx.digit);
    end
    if (dig_q.size() != 0) void'(dig_q.pop_front());
  end
  // hang guard well past the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wait_q();
    while (exp_q.size() != 0) @(negedge clk);
    repeat (20) @(negedge clk);
  endtask
  initial begin
    {rst_n, cpv, trx, setup, rep, wr, alarm, route} = '0;
    {rcnt, idx, dig, wslot, cand, last} = '0;
    tone = PLD_TONE_NONE;
    hold = 4;
    c = $urandom(71);
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    wr = 1'b1;
    for (int s = 0; s < 5; s++) begin
      for (int i = 0; i < 16; i++) begin
        wslot = 3'(s);
        idx = 4'(i);
        dig = (s == 0 || i > 1) ? 4'hf : 4'(s + i);
        @(negedge clk);
      end
    end
    wr = 1'b0;
    rcnt = 4'(1 + $urandom % 3);
    exp_q.push_back(5'h10);
    pld_line_model_inst.ring(rcnt);
    repeat (100) @(negedge clk);
    exp_q.push_back(5'h00);
    pld_line_model_inst.reverse();
    repeat (250) @(negedge clk);
    exp_q.push_back(5'h10);
    pld_line_model_inst.ring(rcnt);
    wait_q();
    exp_q.push_back(5'h00);
    pld_line_model_inst.drop();
    repeat (250) @(negedge clk);
    rcnt = 4'h2;
    pld_line_model_inst.ring(1);
    repeat (250) @(negedge clk);
    pld_line_model_inst.ring(1);
    exp_q.push_back(5'h10);
    pld_line_model_inst.ring(1);
    exp_q.push_back(5'h00);
    pld_line_model_inst.reverse();
    wait_q();
    repeat (250) @(negedge clk);
    setup = 1'b1;
    alarm[0] = 1'b1;
    pld_line_model_inst.ring(2);
    total_checks++;
    if (rly_b !== 1'b1 || rly_a !== 1'b0 || hook !== 1'b0) begin
      fails++;
      $display("BAD %0t exp=%h got=%h", $time, 3'b100, {rly_b, rly_a, hook});
    end
    alarm = '0;
    setup = 1'b0;
    repeat (250) @(negedge clk);
    for (int k = 0; k < 3; k++) begin
      c = $urandom % 16;
      route = '0;
      route[c*3 +: 3] = rt[k][2:0];
      exp_q.push_back({2'b01, rt[k] == 0 ? 3'd1 : 3'(rt[k] - 1)});
      dig_q.push_back(rt[k] == 0 ? 4'h1 : 4'(rt[k] - 1));
      dig_q.push_back(rt[k] == 0 ? 4'h2 : 4'(rt[k]));
      alarm[c] = 1'b1;
      repeat (20) @(negedge clk);
      alarm = '0;
      wait_q();
      exp_q.push_back(5'h00);
      rep = 1'b1;
      repeat (60) @(negedge clk);
      rep = 1'b0;
      wait_q();
    end
    stop_test();
  end
endmodule
`default_nettype wire
